// ===== rtl/dtmr_defs.svh
// Purpose: Addresses, field positions, reset values and timing for the dual down timer
// Assumes: Byte-wide register port, 16-bit address, 125 MHz core clock
// Notes:   Definitions only
`ifndef DTMR_DEFS_SVH
`define DTMR_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define DTMR_ADDR_IRQ_LEVEL   16'hff21
`define DTMR_ADDR_IRQ_ENABLE  16'hff23
`define DTMR_ADDR_IRQ_FLAG    16'hff25
`define DTMR_ADDR_GLOBAL_CTL  16'hff30
`define DTMR_ADDR_T0_CTL      16'hff31
`define DTMR_ADDR_T1_CTL      16'hff32
`define DTMR_ADDR_T0_RELOAD   16'hff33
`define DTMR_ADDR_T1_RELOAD   16'hff34
`define DTMR_ADDR_T0_READOUT  16'hff35
`define DTMR_ADDR_T1_READOUT  16'hff36

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DTMR_BIT_CASCADE      4
`define DTMR_BIT_OUT_SEL      3
`define DTMR_BIT_OUT_EN       2
`define DTMR_BIT_DIV_HI       4
`define DTMR_BIT_DIV_LO       3
`define DTMR_BIT_REPEAT       2
`define DTMR_BIT_PRESET       1
`define DTMR_BIT_RUN          0
`define DTMR_BIT_LEVEL_HI     3
`define DTMR_BIT_LEVEL_LO     2
`define DTMR_BIT_IRQ_T1       7
`define DTMR_BIT_IRQ_T0       6

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DTMR_RELOAD_RST       8'hff
`define DTMR_COUNT_RST        8'hff
`define DTMR_CLK_PERIOD_NS    8
`define DTMR_LATCH_HOLD_NS    730000
`define DTMR_LATCH_HOLD_CYC   ((`DTMR_LATCH_HOLD_NS + `DTMR_CLK_PERIOD_NS - 1) / `DTMR_CLK_PERIOD_NS)

`endif

// ===== rtl/dtmr_pkg.sv
// Purpose: Shared types of the dual down timer
// Assumes: Nothing beyond the defs header
// Notes:   Constants live in dtmr_defs.svh
package dtmr_pkg;
	typedef logic [7:0]  dtmr_byte_t;
	typedef logic [15:0] dtmr_addr_t;
	typedef logic [1:0]  dtmr_level_t;
endpackage : dtmr_pkg

// ===== rtl/dtmr_timer.sv
// Purpose: Two 8-bit down timers, cascadable to 16 bits, with output pins and interrupt request
// Assumes: Timer source clock arrives on a pin from another domain; byte register port
// Notes:   Counting advances on falling edges of the synchronised source clock
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "dtmr_defs.svh"

module dtmr_timer #(
	parameter int LATCH_HOLD_CYC = `DTMR_LATCH_HOLD_CYC
) (
	input  wire logic                core_clk_i,          // Core clock, 125 MHz
	input  wire logic                rst_n_i,             // Asynchronous reset, active low
	input  wire logic                timer_src_clk_i,     // Timer source clock pin
	input  wire dtmr_pkg::dtmr_addr_t addr_i,             // Register address
	input  wire dtmr_pkg::dtmr_byte_t wdata_i,            // Register write data
	input  wire logic                wr_i,                // Write strobe
	input  wire logic                rd_i,                // Read strobe
	output dtmr_pkg::dtmr_byte_t     rdata_o,             // Read data, cycle after strobe
	input  wire dtmr_pkg::dtmr_level_t cpu_mask_level_i,  // Processor interrupt mask level
	output logic                     irq_req_o,           // Interrupt request to processor
	output dtmr_pkg::dtmr_level_t    irq_level_o,         // Level of the request
	output logic                     true_output_pin_o,   // Timer output clock
	output logic                     inverted_output_pin_o // Inverted timer output clock
);
	import dtmr_pkg::*;

	localparam logic [16:0] LATCH_HOLD = 17'(LATCH_HOLD_CYC);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic div_hit(input logic [5:0] pre, input logic [1:0] sel);
		logic [5:0] mask;
		begin
			mask = 6'h00;
			case (sel)
				2'h1:    mask = 6'h03;
				2'h2:    mask = 6'h0f;
				2'h3:    mask = 6'h3f;
				default: mask = 6'h00;
			endcase
			div_hit = ((pre & mask) == mask);
		end
	endfunction : div_hit

	function automatic logic is_wr(input dtmr_addr_t a, input dtmr_addr_t target, input logic w);
		begin
			is_wr = w && (a == target);
		end
	endfunction : is_wr

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic        src_meta_r;
	logic        src_sync_r;
	logic        src_prev_r;
	logic [5:0]  pre_r [2];
	logic        cascade_r;
	logic        out_sel_r;
	logic        out_en_r;
	logic [1:0]  div_r [2];
	logic        repeat_r [2];
	logic        run_req_r [2];
	logic        run_act_r [2];
	dtmr_byte_t  reload_r [2];
	dtmr_byte_t  cnt_r [2];
	dtmr_level_t irq_level_r;
	logic        irq_en_r [2];
	logic        irq_flag_r [2];
	dtmr_byte_t  hold_r;
	logic        latched_r;
	logic [16:0] latch_cnt_r;
	logic        timer_output_clock_r;
	dtmr_byte_t  rdata_nxt;

	logic        src_fall;
	logic        tick [2];
	logic        step0;
	logic        step1;
	logic        uf0;
	logic        uf1;
	logic        uf_comb;
	logic        end0;
	logic        wr_glob;
	logic        wr_ctl [2];
	logic        preset [2];
	logic        rd_low;
	logic        rd_high;
	logic        set0;
	logic        set1;

	// ----------------------------------------------------------------
	// Source clock synchroniser and dividers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			src_meta_r <= 1'b0;
			src_sync_r <= 1'b0;
			src_prev_r <= 1'b0;
		end
		else
		begin
			src_meta_r <= timer_src_clk_i;
			src_sync_r <= src_meta_r;
			src_prev_r <= src_sync_r;
		end
	end

	assign src_fall = src_prev_r & ~src_sync_r;

	// Dividers count source edges; one tick per completed ratio
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pre_r[0] <= 6'h00;
			pre_r[1] <= 6'h00;
		end
		else if (src_fall)
		begin
			pre_r[0] <= pre_r[0] + 6'h01;
			pre_r[1] <= pre_r[1] + 6'h01;
		end
	end

	assign tick[0] = src_fall & div_hit(pre_r[0], div_r[0]);
	assign tick[1] = src_fall & div_hit(pre_r[1], div_r[1]);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign wr_glob   = is_wr(addr_i, `DTMR_ADDR_GLOBAL_CTL, wr_i);
	assign wr_ctl[0] = is_wr(addr_i, `DTMR_ADDR_T0_CTL, wr_i);
	assign wr_ctl[1] = is_wr(addr_i, `DTMR_ADDR_T1_CTL, wr_i);
	assign preset[0] = wr_ctl[0] & wdata_i[`DTMR_BIT_PRESET];
	assign preset[1] = wr_ctl[1] & wdata_i[`DTMR_BIT_PRESET] & ~cascade_r;
	assign rd_low    = rd_i && (addr_i == `DTMR_ADDR_T0_READOUT);
	assign rd_high   = rd_i && (addr_i == `DTMR_ADDR_T1_READOUT);

	// ----------------------------------------------------------------
	// Underflow detection
	// ----------------------------------------------------------------
	// The count step uses the active run state, so a stop still decrements once
	assign step0   = tick[0] & run_act_r[0];
	assign uf0     = step0 & (cnt_r[0] == 8'h00);
	assign step1   = cascade_r ? uf0 : (tick[1] & run_act_r[1]);
	assign uf1     = step1 & (cnt_r[1] == 8'h00);
	assign uf_comb = cascade_r & uf1;
	assign end0    = cascade_r ? uf_comb : uf0;

	// ----------------------------------------------------------------
	// Global control
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cascade_r <= 1'b0;
			out_sel_r <= 1'b0;
			out_en_r  <= 1'b0;
		end
		else if (wr_glob)
		begin
			cascade_r <= wdata_i[`DTMR_BIT_CASCADE];
			out_sel_r <= wdata_i[`DTMR_BIT_OUT_SEL];
			out_en_r  <= wdata_i[`DTMR_BIT_OUT_EN];
		end
	end

	// ----------------------------------------------------------------
	// Per-timer configuration and reload values
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < 2; i++)
			begin
				div_r[i]    <= 2'h0;
				repeat_r[i] <= 1'b0;
				reload_r[i] <= `DTMR_RELOAD_RST;
			end
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (wr_ctl[i])
				begin
					div_r[i]    <= wdata_i[`DTMR_BIT_DIV_HI:`DTMR_BIT_DIV_LO];
					repeat_r[i] <= wdata_i[`DTMR_BIT_REPEAT];
				end
			end
			if (is_wr(addr_i, `DTMR_ADDR_T0_RELOAD, wr_i))
				reload_r[0] <= wdata_i;
			if (is_wr(addr_i, `DTMR_ADDR_T1_RELOAD, wr_i))
				reload_r[1] <= wdata_i;
		end
	end

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	// Request is software's; active state follows it on a divided source edge, but timer 1's clears at once in cascade
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			run_req_r[0] <= 1'b0;
			run_req_r[1] <= 1'b0;
			run_act_r[0] <= 1'b0;
			run_act_r[1] <= 1'b0;
		end
		else
		begin
			if (end0 && !repeat_r[0])
				run_req_r[0] <= 1'b0;
			if (wr_ctl[0])
				run_req_r[0] <= wdata_i[`DTMR_BIT_RUN];
			if (end0 && !repeat_r[0])
				run_act_r[0] <= 1'b0;
			else if (tick[0])
				run_act_r[0] <= run_req_r[0];

			if (cascade_r)
				run_req_r[1] <= 1'b0;
			else if (wr_ctl[1])
				run_req_r[1] <= wdata_i[`DTMR_BIT_RUN];
			else if (uf1 && !repeat_r[1])
				run_req_r[1] <= 1'b0;
			if (cascade_r || (uf1 && !repeat_r[1]))
				run_act_r[1] <= 1'b0;
			else if (tick[1])
				run_act_r[1] <= run_req_r[1];
		end
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	// In cascade the low half wraps through ff on its own borrow, like a true 16-bit count
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_r[0] <= `DTMR_COUNT_RST;
			cnt_r[1] <= `DTMR_COUNT_RST;
		end
		else
		begin
			if (preset[0])
				cnt_r[0] <= reload_r[0];
			else if (step0)
			begin
				if (uf0 && (!cascade_r || uf_comb))
					cnt_r[0] <= reload_r[0];
				else
					cnt_r[0] <= cnt_r[0] - 8'h01;
			end

			if (preset[1] || (cascade_r && preset[0]))
				cnt_r[1] <= reload_r[1];
			else if (step1)
			begin
				if (uf1)
					cnt_r[1] <= reload_r[1];
				else
					cnt_r[1] <= cnt_r[1] - 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// High-byte readout latch
	// ----------------------------------------------------------------
	// Holds the timer 1 readout between the two reads so a borrow cannot split the value
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hold_r      <= `DTMR_COUNT_RST;
			latched_r   <= 1'b0;
			latch_cnt_r <= 17'h00000;
		end
		else if (rd_low && cascade_r)
		begin
			hold_r      <= cnt_r[1];
			latched_r   <= 1'b1;
			latch_cnt_r <= LATCH_HOLD;
		end
		else if (rd_high || (latched_r && latch_cnt_r == 17'h00001))
		begin
			latched_r   <= 1'b0;
			latch_cnt_r <= 17'h00000;
		end
		else if (latched_r)
			latch_cnt_r <= latch_cnt_r - 17'h00001;
	end

	// ----------------------------------------------------------------
	// Interrupt control
	// ----------------------------------------------------------------
	assign set0 = uf0 & ~cascade_r;
	assign set1 = cascade_r ? uf_comb : uf1;

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			irq_level_r <= 2'h0;
			irq_en_r[0] <= 1'b0;
			irq_en_r[1] <= 1'b0;
		end
		else
		begin
			if (is_wr(addr_i, `DTMR_ADDR_IRQ_LEVEL, wr_i))
				irq_level_r <= wdata_i[`DTMR_BIT_LEVEL_HI:`DTMR_BIT_LEVEL_LO];
			if (is_wr(addr_i, `DTMR_ADDR_IRQ_ENABLE, wr_i))
			begin
				irq_en_r[0] <= wdata_i[`DTMR_BIT_IRQ_T0];
				irq_en_r[1] <= wdata_i[`DTMR_BIT_IRQ_T1];
			end
		end
	end

	// A new underflow beats a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			irq_flag_r[0] <= 1'b0;
			irq_flag_r[1] <= 1'b0;
		end
		else
		begin
			if (set0)
				irq_flag_r[0] <= 1'b1;
			else if (is_wr(addr_i, `DTMR_ADDR_IRQ_FLAG, wr_i) && wdata_i[`DTMR_BIT_IRQ_T0])
				irq_flag_r[0] <= 1'b0;
			if (set1)
				irq_flag_r[1] <= 1'b1;
			else if (is_wr(addr_i, `DTMR_ADDR_IRQ_FLAG, wr_i) && wdata_i[`DTMR_BIT_IRQ_T1])
				irq_flag_r[1] <= 1'b0;
		end
	end

	always_comb
	begin
		irq_level_o = irq_level_r;
		irq_req_o   = (irq_level_r > cpu_mask_level_i) &&
		              ((irq_flag_r[0] && irq_en_r[0] && !cascade_r) ||
		               (irq_flag_r[1] && irq_en_r[1]));
	end

	// ----------------------------------------------------------------
	// Timer output
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			timer_output_clock_r <= 1'b0;
		else if (cascade_r ? uf_comb : (out_sel_r ? uf0 : uf1))
			timer_output_clock_r <= ~timer_output_clock_r;
	end

	// Plain gate after the flop; toggling the enable can clip an output half cycle
	always_comb
	begin
		true_output_pin_o     = out_en_r ? timer_output_clock_r : 1'b1;
		inverted_output_pin_o = out_en_r ? ~timer_output_clock_r : 1'b0;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_nxt = 8'h00;
		case (addr_i)
			`DTMR_ADDR_GLOBAL_CTL:
			begin
				rdata_nxt[`DTMR_BIT_CASCADE] = cascade_r;
				rdata_nxt[`DTMR_BIT_OUT_SEL] = out_sel_r;
				rdata_nxt[`DTMR_BIT_OUT_EN]  = out_en_r;
			end
			`DTMR_ADDR_T0_CTL, `DTMR_ADDR_T1_CTL:
			begin
				// Preset bit position stays zero
				rdata_nxt[`DTMR_BIT_DIV_HI:`DTMR_BIT_DIV_LO] = div_r[addr_i[1]];
				rdata_nxt[`DTMR_BIT_REPEAT] = repeat_r[addr_i[1]];
				rdata_nxt[`DTMR_BIT_RUN]    = run_req_r[addr_i[1]] | run_act_r[addr_i[1]];
			end
			`DTMR_ADDR_T0_RELOAD:  rdata_nxt = reload_r[0];
			`DTMR_ADDR_T1_RELOAD:  rdata_nxt = reload_r[1];
			`DTMR_ADDR_T0_READOUT: rdata_nxt = cnt_r[0];
			`DTMR_ADDR_T1_READOUT: rdata_nxt = latched_r ? hold_r : cnt_r[1];
			`DTMR_ADDR_IRQ_LEVEL:
				rdata_nxt[`DTMR_BIT_LEVEL_HI:`DTMR_BIT_LEVEL_LO] = irq_level_r;
			`DTMR_ADDR_IRQ_ENABLE:
			begin
				rdata_nxt[`DTMR_BIT_IRQ_T0] = irq_en_r[0];
				rdata_nxt[`DTMR_BIT_IRQ_T1] = irq_en_r[1];
			end
			`DTMR_ADDR_IRQ_FLAG:
			begin
				rdata_nxt[`DTMR_BIT_IRQ_T0] = irq_flag_r[0];
				rdata_nxt[`DTMR_BIT_IRQ_T1] = irq_flag_r[1];
			end
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= rdata_nxt;
		else
			rdata_o <= 8'h00;
	end

endmodule : dtmr_timer

// ===== dv/dtmr_timer_properties.sv
// Purpose: Port-level assertions for the dual down timer
// Assumes: Control writes take effect at the strobe edge
// Notes:   Keeps shadows of a few control bits seen on the write port
`timescale 1ns/10ps

module dtmr_timer_props
	import dtmr_pkg::*;
#(
	parameter int LATCH_HOLD_CYC = 20
) (
	input  wire logic        core_clk_i,            // Core clock
	input  wire logic        rst_n_i,               // Reset, active low
	input  wire logic        timer_src_clk_i,       // Timer source clock
	input  wire dtmr_addr_t  addr_i,                // Register address
	input  wire dtmr_byte_t  wdata_i,               // Write data
	input  wire logic        wr_i,                  // Write strobe
	input  wire logic        rd_i,                  // Read strobe
	input  wire dtmr_byte_t  rdata_o,               // Read data
	input  wire dtmr_level_t cpu_mask_level_i,      // Mask level
	input  wire logic        irq_req_o,             // Interrupt request
	input  wire dtmr_level_t irq_level_o,           // Request level
	input  wire logic        true_output_pin_o,     // True pin
	input  wire logic        inverted_output_pin_o  // Inverted pin
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	logic       out_en_r;
	logic       sel_r;
	logic       casc_r;
	logic [1:0] lvl_r;
	logic [1:0] en_r;

	// ----------------------------------------------------------------
	// Control shadows
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			{casc_r, sel_r, out_en_r} <= 3'b000;
			lvl_r                     <= 2'b00;
			en_r                      <= 2'b00;
		end
		else if (wr_i)
		begin
			if (addr_i == 16'hff30)
				{casc_r, sel_r, out_en_r} <= wdata_i[4:2];
			if (addr_i == 16'hff21)
				lvl_r <= wdata_i[3:2];
			if (addr_i == 16'hff23)
				en_r <= wdata_i[7:6];
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	pins_parked_a: assert property (!out_en_r |-> true_output_pin_o && !inverted_output_pin_o)
		else $error("pins not parked while output disabled");
	pins_inverse_a: assert property (out_en_r |-> inverted_output_pin_o == !true_output_pin_o)
		else $error("inverted pin not the inverse of true pin");
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read answer cycle");
	preset_zero_a: assert property (rd_i && (addr_i == 16'hff31 || addr_i == 16'hff32) |=> !rdata_o[1])
		else $error("preset bit read as one");
	casc_run_a: assert property (rd_i && addr_i == 16'hff32 && casc_r |=> !rdata_o[0])
		else $error("timer 1 run bit set in cascade mode");
	global_read_a: assert property ($past(rd_i) && $past(addr_i) == 16'hff30
		|-> rdata_o == {3'b000, $past(casc_r), $past(sel_r), $past(out_en_r), 2'b00})
		else $error("global control read back wrong");
	level_out_a: assert property (irq_level_o == lvl_r)
		else $error("interrupt level differs from written field");
	level_read_a: assert property (rd_i && addr_i == 16'hff21 |=> rdata_o[3:2] == $past(lvl_r))
		else $error("interrupt level read back wrong");
	enable_read_a: assert property (rd_i && addr_i == 16'hff23 |=> rdata_o[7:6] == $past(en_r))
		else $error("interrupt enables read back wrong");
	irq_gate_a: assert property (irq_req_o
		|-> irq_level_o > cpu_mask_level_i && (en_r[1] || (en_r[0] && !casc_r)))
		else $error("interrupt request without enable or level");
endmodule : dtmr_timer_props

bind dtmr_timer dtmr_timer_props #(.LATCH_HOLD_CYC(LATCH_HOLD_CYC)) u_props (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .timer_src_clk_i(timer_src_clk_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.cpu_mask_level_i(cpu_mask_level_i), .irq_req_o(irq_req_o), .irq_level_o(irq_level_o),
	.true_output_pin_o(true_output_pin_o), .inverted_output_pin_o(inverted_output_pin_o)
);

// ===== dv/dtmr_timer_test.sv
// Purpose: Self-checking bench for the dual down timer
// Assumes: Source clock driven slowly against the core clock
// Notes:   Short latch hold; counts derived from source falling edges
`timescale 1ns/10ps

module dual_programmable_down_timer_test;
	import dtmr_pkg::*;
	logic        core_clk_i;
	logic        rst_n_i;
	logic        src_clk;
	dtmr_addr_t  addr;
	dtmr_byte_t  wdata;
	dtmr_byte_t  rdata;
	dtmr_byte_t  got;
	dtmr_byte_t  r;
	logic        wr;
	logic        rd;
	logic        irq_req;
	logic        tpin;
	logic        ipin;
	dtmr_level_t mask;
	dtmr_level_t lvl;
	int          errors;
	int          cmp_count;
	logic [31:0] lfsr_r;

	dtmr_timer #(.LATCH_HOLD_CYC(30)) dut (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .timer_src_clk_i(src_clk), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cpu_mask_level_i(mask),
		.irq_req_o(irq_req), .irq_level_o(lvl), .true_output_pin_o(tpin), .inverted_output_pin_o(ipin)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic dtmr_byte_t rnd8();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r[7:0];
	endfunction : rnd8

	// Two ticks of any divider setting
	function automatic int two_ticks(input int d);
		return 2 << (2 * d);
	endfunction : two_ticks

	task automatic reg_wr(input dtmr_addr_t a, input dtmr_byte_t d);
		@(posedge core_clk_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic chk8(input string name, input dtmr_byte_t exp, input dtmr_byte_t seen);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk8

	task automatic rd_chk(input dtmr_addr_t a, input dtmr_byte_t exp, input string name);
		@(posedge core_clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1;
		chk8(name, exp, rdata);
	endtask : rd_chk

	task automatic chk_pins(input logic t, input logic i); // Port data of true pin taken as set
		#1;
		chk8("true pin", {7'h00, t}, {7'h00, tpin});
		chk8("inverted pin", {7'h00, i}, {7'h00, ipin});
	endtask : chk_pins

	task automatic chk_irq(input logic exp);
		#1;
		chk8("irq request", {7'h00, exp}, {7'h00, irq_req});
	endtask : chk_irq

	// Slow source: a falling edge every 12 core cycles, stable from the start
	task automatic src_edges(input int n);
		repeat (n)
		begin
			repeat (6) @(posedge core_clk_i);
			src_clk <= 1'b0;
			repeat (6) @(posedge core_clk_i);
			src_clk <= 1'b1;
		end
		repeat (6) @(posedge core_clk_i);
	endtask : src_edges

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Clock, watchdog
	// ----------------------------------------------------------------
	initial
	begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	initial
	begin
		repeat (40000) @(posedge core_clk_i);
		errors++;
		$display("Error watchdog expected end seen hang");
		complete_run();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		rst_n_i   = 1'b0;
		src_clk   = 1'b1;
		addr      = 16'h0000;
		wdata     = 8'h00;
		wr        = 1'b0;
		rd        = 1'b0;
		mask      = 2'b00;
		errors    = 0;
		cmp_count = 0;
		lfsr_r    = 32'h72746798;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;

		rd_chk(16'hff35, 8'hff, "count0 reset");
		rd_chk(16'hff36, 8'hff, "count1 reset");
		rd_chk(16'hff33, 8'hff, "reload0 reset");
		rd_chk(16'hff34, 8'hff, "reload1 reset");
		rd_chk(16'hff30, 8'h00, "global reset");
		rd_chk(16'hff31, 8'h00, "ctl0 reset");
		rd_chk(16'hff21, 8'h00, "level reset");
		rd_chk(16'hff23, 8'h00, "enable reset");
		rd_chk(16'hff25, 8'h00, "flag reset");
		rd_chk(16'hff22, 8'h00, "unmapped");
		reg_wr(16'hff35, rnd8());
		rd_chk(16'hff35, 8'hff, "count0 after write");
		$display("test reset done");

		r = rnd8() | 8'h40;
		reg_wr(16'hff33, r);
		reg_wr(16'hff31, 8'h02);
		rd_chk(16'hff35, r, "preset count");
		rd_chk(16'hff31, 8'h00, "preset reads zero");
		reg_wr(16'hff33, ~r);
		reg_wr(16'hff31, 8'h00);
		rd_chk(16'hff35, r, "zero preset");
		reg_wr(16'hff33, r);
		for (int d = 0; d < 4; d++)
		begin
			reg_wr(16'hff31, 8'h02);
			reg_wr(16'hff31, {3'b000, d[1:0], 3'b001});
			src_edges(two_ticks(d));
			rd_chk(16'hff35, r - 8'h01, "run count");
			reg_wr(16'hff31, {3'b000, d[1:0], 3'b000});
			rd_chk(16'hff31, {3'b000, d[1:0], 3'b001}, "run pending stop");
			src_edges(two_ticks(d));
			rd_chk(16'hff35, r - 8'h02, "stop count");
			rd_chk(16'hff31, {3'b000, d[1:0], 3'b000}, "stopped");
		end
		$display("test run stop done");

		reg_wr(16'hff33, 8'h02);
		reg_wr(16'hff31, 8'h02);
		reg_wr(16'hff30, 8'h0c);
		reg_wr(16'hff21, 8'h08);
		reg_wr(16'hff23, 8'h40);
		mask <= 2'b01;
		chk_pins(1'b0, 1'b1);
		chk8("irq level", 8'h02, {6'h00, lvl});
		reg_wr(16'hff31, 8'h01);
		src_edges(4);
		rd_chk(16'hff31, 8'h00, "one shot stop");
		rd_chk(16'hff35, 8'h02, "one shot reload");
		rd_chk(16'hff25, 8'h40, "flag0 set");
		chk_irq(1'b1);
		chk_pins(1'b1, 1'b0);
		@(posedge core_clk_i);
		mask <= 2'b10;
		@(posedge core_clk_i);
		chk_irq(1'b0);
		reg_wr(16'hff25, 8'h00);
		rd_chk(16'hff25, 8'h40, "flag kept");
		reg_wr(16'hff25, 8'h40);
		rd_chk(16'hff25, 8'h00, "flag cleared");
		$display("test one shot done");

		reg_wr(16'hff30, 8'h04);
		reg_wr(16'hff34, 8'h01);
		mask <= 2'b00;
		reg_wr(16'hff32, 8'h07);
		src_edges(7);
		rd_chk(16'hff32, 8'h05, "continuous runs");
		rd_chk(16'hff36, 8'h01, "continuous count");
		rd_chk(16'hff25, 8'h80, "flag1 unenabled");
		chk_irq(1'b0);
		chk_pins(1'b0, 1'b1);
		reg_wr(16'hff30, 8'h00);
		chk_pins(1'b1, 1'b0);
		reg_wr(16'hff32, 8'h00);
		src_edges(2);
		$display("test continuous done");

		reg_wr(16'hff25, 8'hc0);
		reg_wr(16'hff30, 8'h1c);
		reg_wr(16'hff33, 8'h01);
		r = rnd8() | 8'h10;
		reg_wr(16'hff34, r);
		reg_wr(16'hff32, 8'h03);
		rd_chk(16'hff32, 8'h00, "cascade timer1 ctl");
		rd_chk(16'hff36, 8'h00, "cascade preset1 ignored");
		reg_wr(16'hff31, 8'h02);
		rd_chk(16'hff36, r, "cascade high");
		reg_wr(16'hff31, 8'h01);
		src_edges(2);
		rd_chk(16'hff35, 8'h00, "cascade low");
		src_edges(1);
		rd_chk(16'hff36, r, "latched high");
		rd_chk(16'hff36, r - 8'h01, "released high");
		rd_chk(16'hff35, 8'hff, "low wrapped");
		chk_pins(1'b0, 1'b1);
		reg_wr(16'hff31, 8'h00);
		src_edges(1);
		reg_wr(16'hff33, 8'h00);
		reg_wr(16'hff34, 8'h00);
		reg_wr(16'hff31, 8'h02);
		reg_wr(16'hff31, 8'h01);
		src_edges(2);
		rd_chk(16'hff25, 8'h80, "cascade flags");
		rd_chk(16'hff31, 8'h00, "cascade one shot");
		chk_irq(1'b0);
		rd_chk(16'hff36, 8'h00, "latch timed out");
		chk_pins(1'b1, 1'b0);
		reg_wr(16'hff30, 8'h00);
		$display("test cascade done");
		complete_run();
	end
endmodule : dual_programmable_down_timer_test
